// *** rtl/tlvic_defs.svh ***
`ifndef TLVIC_DEFS_SVH
`define TLVIC_DEFS_SVH
// register indices; byte address is four times the index
`define TLVIC_IDX_EXT_FLAGS 8'h91
`define TLVIC_IDX_RELOC 8'h9d
`define TLVIC_IDX_WAKE_MASK 8'h9f
`define TLVIC_IDX_PIN_RISE 8'ha2
`define TLVIC_IDX_PIN_FALL 8'ha3
`define TLVIC_IDX_PIN_FLAGS 8'ha4
`define TLVIC_IDX_BASIC_EN 8'ha8
`define TLVIC_IDX_BASIC_PRIO 8'hb8
`define TLVIC_IDX_STATUS 8'hc5
`define TLVIC_IDX_UNLOCK 8'hc9
`define TLVIC_IDX_EXT_EN 8'he8
`define TLVIC_IDX_EXT_PRIO 8'hf8
// reset values
`define TLVIC_RST_ZERO 8'h00
`define TLVIC_RST_WAKE_MASK 8'hff
// field positions
`define TLVIC_GIE_BIT 7
`define TLVIC_RELOC_BIT 5
`define TLVIC_I2C_MST_FLAG_BIT 0
`define TLVIC_DBG_FLAG_BIT 1
`define TLVIC_BKPT_FLAG_BIT 0
// source indices in natural order, index 0 is position 1
`define TLVIC_SRC_TIMER0 4'd1
`define TLVIC_SRC_TIMER1 4'd3
// vectors
`define TLVIC_VEC_BASE 16'h0003
`define TLVIC_DBG_VEC_LOW 12'h0c0
`define TLVIC_BKPT_VEC_LOW 12'h080
`define TLVIC_NIB_64K 4'hf
`define TLVIC_NIB_48K 4'hb
`define TLVIC_NIB_32K 4'h7
`define TLVIC_NIB_16K 4'h3
`define TLVIC_RELOC_NIBBLE `TLVIC_NIB_32K
// timed write unlock
`define TLVIC_UNLOCK_CYCLES 9'd256
`define TLVIC_UNLOCK_KEY1 8'haa
`define TLVIC_UNLOCK_KEY2 8'h55
`define TLVIC_UNLOCK_CLOSE 8'h00
`endif

// *** rtl/tlvic_pkg.sv ***
package tlvic_pkg;
	// service classes, ordered so that a larger value preempts a smaller one
	typedef enum logic [1:0] {CLS_NONE, CLS_LOW, CLS_HIGH, CLS_DBG} tlvic_cls_t;
	typedef enum logic {UNLK_IDLE, UNLK_ARMED} tlvic_unlk_t;
endpackage

// *** rtl/tlvic_top.sv ***
`timescale 1ns/100ps
`include "tlvic_defs.svh"
// Behaviour
// RULE_01: fifteen peripheral sources, each set high or low level by software.
// RULE_02: all request inputs are registered on every rising clock edge first.
// RULE_03: with enabled requests pending, present the vector of the best one.
// RULE_04: high level beats low; within a level lower position wins.
// RULE_05: normal vectors start 0x0003, step 8 per position, up to 0x007B.
// RULE_06: relocated vectors replace the top nibble by the memory-size nibble.
// RULE_07: only timer 0 and timer 1 flags are cleared by hardware on vectoring.
// RULE_08: software writes may clear flags but can never set them.
// RULE_09: debug over breakpoint over all others, vectors X0C0 and X080.
// RULE_10: debug raised on matching id in debug-port mode; breakpoint on match.
// RULE_11: debug and breakpoint ignore the global enable.
// RULE_12: basic enable register layout, global enable gates all peripheral sources.
// RULE_13: extended enable register layout for the eight extended sources.
// RULE_14: priority bits mirror enable positions, one means high, reset zero.
// RULE_15: extended flag bits 7..1 mirror peripheral flags, read-only. Here bit 4 always reads zero.
// RULE_16: i2c master flag at bit 0, sticky until software clears it.
// RULE_17: wake mask resets to ones, selects eight sources that may wake.
// RULE_18: wake always reacts to an edge, even for level interrupts.
// RULE_19: wake ignores interrupt enables; core just resumes if disabled.
// RULE_20: clock restart on wake only while the internal oscillator runs.
// RULE_21: pin groups detect rise, fall or both; same event drives irq and wake.
// RULE_22: wake mask writes only land while the timed unlock is open.
// RULE_23: status shows high and low level service in progress.
// RULE_24: unlock sequence opens a 256 cycle write window.
// RULE_25: relocation select bit moves vectors to the boot area.
// RULE_26: high preempts low service; only debug and breakpoint preempt high service.
// RULE_27: shared vector requested while any sharer's flag is set.
module tlvic_top
	import tlvic_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic timer0_overflow_flag_i,
	input wire logic timer1_overflow_flag_i,
	input wire logic timer2_flag_i,
	input wire logic uart0_txrx_flags_i,
	input wire logic uart2_txrx_flags_i,
	input wire logic i2c_master_irq_i,
	input wire logic low_voltage_irq_i,
	input wire logic touch_key_irq_i,
	input wire logic reserved_irq_i,
	input wire logic watchdog_irq_flag_i,
	input wire logic pwm_capture_quad_irq_i,
	input wire logic spi_i2cslave_irq_i,
	input wire logic timers_buzzer_irq_i,
	input wire logic mem_error_irq_i,
	input wire logic [7:0] pin_group0_pins_i,
	input wire logic [7:0] pin_group1_pins_i,
	input wire logic dbg_port_mode_i,
	input wire logic dbg_host_req_i,
	input wire logic [7:0] dbg_host_id_i,
	input wire logic [7:0] dbg_id_cfg_i,
	input wire logic breakpoint_match_i,
	input wire logic irq_ack_i,
	input wire logic irq_return_i,
	input wire logic osc_running_i,
	output logic irq_req_o,
	output logic [15:0] irq_vector_o,
	output logic timer0_flag_clear_o,
	output logic timer1_flag_clear_o,
	output logic wake_o,
	output logic clk_restart_o
);
////////////////////////////////////////////////////////////////////////////////
logic [7:0] basic_en_reg;
logic [6:0] basic_prio_reg;
logic [7:0] ext_en_reg;
logic [7:0] ext_prio_reg;
logic [7:0] wake_mask_reg;
logic [7:0] pin_rise_reg;
logic [7:0] pin_fall_reg;
logic reloc_reg;
logic [1:0] pin_flag_reg;
logic i2c_mst_flag_reg;
logic dbg_flag_reg;
logic bkpt_flag_reg;
logic high_svc_reg;
logic low_svc_reg;
logic dbg_is_reg;
logic [15:0] src_reg;
logic [15:0] src_prev_reg;
logic [15:0] pin_reg;
logic [15:0] pin_prev_reg;
logic i2c_mst_in_reg;
logic dbg_in_reg;
logic bkpt_in_reg;
logic ack_reg;
logic [31:0] dat_reg;
logic req_reg;
logic [15:0] vec_reg;
tlvic_cls_t cls_reg;
logic [3:0] idx_reg;
logic t0_clr_reg;
logic t1_clr_reg;
logic wake_reg;
logic restart_reg;
tlvic_unlk_t unlk_state_reg;
logic [8:0] unlk_cnt_reg;
////////////////////////////////////////////////////////////////////////////////
// bus decode
logic bus_req_w;
logic wr_w;
logic [7:0] idx_w;
logic [7:0] wd_w;
assign bus_req_w = cyc_i & stb_i;
// writes land on the edge where the master sees ack
assign wr_w = bus_req_w & we_i & ack_reg & sel_i[0];
assign idx_w = adr_i[9:2];
assign wd_w = dat_i[7:0];
logic wr_ext_flags_w;
logic wr_status_w;
logic wr_pin_flags_w;
logic wr_unlock_w;
logic unlocked_w;
assign wr_ext_flags_w = wr_w && idx_w == `TLVIC_IDX_EXT_FLAGS;
assign wr_status_w = wr_w && idx_w == `TLVIC_IDX_STATUS;
assign wr_pin_flags_w = wr_w && idx_w == `TLVIC_IDX_PIN_FLAGS;
assign wr_unlock_w = wr_w && idx_w == `TLVIC_IDX_UNLOCK;
assign unlocked_w = unlk_cnt_reg != 9'd0;
////////////////////////////////////////////////////////////////////////////////
// input sampling and pin edge detection
logic [15:0] src_in_w;
logic [15:0] pin_evt_w;
logic [1:0] grp_evt_w;
logic dbg_evt_w;
assign src_in_w = {mem_error_irq_i, timers_buzzer_irq_i, spi_i2cslave_irq_i,
	pwm_capture_quad_irq_i, watchdog_irq_flag_i, reserved_irq_i, touch_key_irq_i,
	low_voltage_irq_i, 1'b0, uart2_txrx_flags_i, timer2_flag_i, uart0_txrx_flags_i,
	timer1_overflow_flag_i, 1'b0, timer0_overflow_flag_i, 1'b0};
assign dbg_evt_w = dbg_port_mode_i & dbg_host_req_i & (dbg_host_id_i == dbg_id_cfg_i); // RULE_10
always_ff @(posedge clk_i) begin
	if (rst_i) begin
		src_reg <= 16'h0000;
		src_prev_reg <= 16'h0000;
		pin_reg <= 16'h0000;
		pin_prev_reg <= 16'h0000;
		i2c_mst_in_reg <= 1'b0;
		dbg_in_reg <= 1'b0;
		bkpt_in_reg <= 1'b0;
	end else begin
		src_reg <= src_in_w; // RULE_02
		src_prev_reg <= src_reg;
		pin_reg <= {pin_group1_pins_i, pin_group0_pins_i}; // RULE_02
		pin_prev_reg <= pin_reg;
		i2c_mst_in_reg <= i2c_master_irq_i;
		dbg_in_reg <= dbg_evt_w;
		bkpt_in_reg <= breakpoint_match_i; // RULE_10
	end
end
genvar g;
generate
	for (g = 0; g < 16; g++) begin : g_pin
		// both groups share one rise and one fall select per pin number
		assign pin_evt_w[g] = (pin_reg[g] & ~pin_prev_reg[g] & pin_rise_reg[g % 8]) |
			(~pin_reg[g] & pin_prev_reg[g] & pin_fall_reg[g % 8]); // RULE_21
	end
endgenerate
assign grp_evt_w = {|pin_evt_w[15:8], |pin_evt_w[7:0]};
////////////////////////////////////////////////////////////////////////////////
// sticky flags: a hardware set beats a software clear in the same cycle
always_ff @(posedge clk_i) begin
	if (rst_i) begin
		pin_flag_reg <= 2'b00;
		i2c_mst_flag_reg <= 1'b0;
		dbg_flag_reg <= 1'b0;
		bkpt_flag_reg <= 1'b0;
	end else begin
		pin_flag_reg <= grp_evt_w | (pin_flag_reg & ~({2{wr_pin_flags_w}} & ~wd_w[1:0])); // RULE_08
		i2c_mst_flag_reg <= i2c_mst_in_reg |
			(i2c_mst_flag_reg & ~(wr_ext_flags_w & ~wd_w[`TLVIC_I2C_MST_FLAG_BIT])); // RULE_16
		dbg_flag_reg <= dbg_in_reg |
			(dbg_flag_reg & ~(wr_status_w & ~wd_w[`TLVIC_DBG_FLAG_BIT])); // RULE_08
		bkpt_flag_reg <= bkpt_in_reg |
			(bkpt_flag_reg & ~(wr_status_w & ~wd_w[`TLVIC_BKPT_FLAG_BIT]));
	end
end
////////////////////////////////////////////////////////////////////////////////
// configuration registers
always_ff @(posedge clk_i) begin
	if (rst_i) begin
		basic_en_reg <= `TLVIC_RST_ZERO;
		basic_prio_reg <= 7'h00;
		ext_en_reg <= `TLVIC_RST_ZERO;
		ext_prio_reg <= `TLVIC_RST_ZERO; // RULE_14
		wake_mask_reg <= `TLVIC_RST_WAKE_MASK; // RULE_17
		pin_rise_reg <= `TLVIC_RST_ZERO;
		pin_fall_reg <= `TLVIC_RST_ZERO;
		reloc_reg <= 1'b0;
	end else if (wr_w) begin
		if (idx_w == `TLVIC_IDX_BASIC_EN)
			basic_en_reg <= wd_w; // RULE_12
		if (idx_w == `TLVIC_IDX_BASIC_PRIO)
			basic_prio_reg <= wd_w[6:0]; // RULE_14
		if (idx_w == `TLVIC_IDX_EXT_EN)
			ext_en_reg <= wd_w; // RULE_13
		if (idx_w == `TLVIC_IDX_EXT_PRIO)
			ext_prio_reg <= wd_w;
		if (idx_w == `TLVIC_IDX_WAKE_MASK && unlocked_w)
			wake_mask_reg <= wd_w; // RULE_22
		if (idx_w == `TLVIC_IDX_PIN_RISE)
			pin_rise_reg <= wd_w;
		if (idx_w == `TLVIC_IDX_PIN_FALL)
			pin_fall_reg <= wd_w;
		if (idx_w == `TLVIC_IDX_RELOC)
			reloc_reg <= wd_w[`TLVIC_RELOC_BIT]; // RULE_25
	end
end
////////////////////////////////////////////////////////////////////////////////
// timed write unlock: key1 then key2 opens or extends, close word shuts it
always_ff @(posedge clk_i) begin
	if (rst_i) begin
		unlk_state_reg <= UNLK_IDLE;
		unlk_cnt_reg <= 9'd0;
	end else if (wr_unlock_w) begin
		case (unlk_state_reg)
			UNLK_IDLE: begin
				unlk_state_reg <= (wd_w == `TLVIC_UNLOCK_KEY1) ? UNLK_ARMED : UNLK_IDLE;
				if (wd_w == `TLVIC_UNLOCK_CLOSE)
					unlk_cnt_reg <= 9'd0;
				else if (unlocked_w)
					unlk_cnt_reg <= unlk_cnt_reg - 9'd1;
			end
			UNLK_ARMED: begin
				unlk_state_reg <= (wd_w == `TLVIC_UNLOCK_KEY1) ? UNLK_ARMED : UNLK_IDLE;
				if (wd_w == `TLVIC_UNLOCK_KEY2)
					unlk_cnt_reg <= `TLVIC_UNLOCK_CYCLES; // RULE_24
				else if (wd_w == `TLVIC_UNLOCK_CLOSE)
					unlk_cnt_reg <= 9'd0;
				else if (unlocked_w)
					unlk_cnt_reg <= unlk_cnt_reg - 9'd1;
			end
			default: begin
				unlk_state_reg <= UNLK_IDLE;
			end
		endcase
	end else if (unlocked_w) begin
		unlk_cnt_reg <= unlk_cnt_reg - 9'd1; // RULE_24
	end
end
////////////////////////////////////////////////////////////////////////////////
// arbitration
logic [15:0] flag_w;
logic [15:0] pend_w;
logic [15:0] en_w;
logic [15:0] prio_w;
logic [15:0] hi_w;
logic [15:0] lo_w;
logic [3:0] hi_idx;
logic [3:0] lo_idx;
// sharers are or-ed by their peripheral, pin group pins here in grp_evt_w; the routine finds the source itself
assign flag_w = {8'h00, i2c_mst_flag_reg, 4'h0, pin_flag_reg[1], 1'b0, pin_flag_reg[0]};
assign pend_w = src_reg | flag_w; // RULE_27
// position 16 (memory error) has no enable bit of its own and stays low level
assign en_w = {1'b1, ext_en_reg, basic_en_reg[6:0]} &
	{16{basic_en_reg[`TLVIC_GIE_BIT]}}; // RULE_12
assign prio_w = {1'b0, ext_prio_reg, basic_prio_reg}; // RULE_01
assign hi_w = pend_w & en_w & prio_w;
assign lo_w = pend_w & en_w & ~prio_w;
always_comb begin
	hi_idx = 4'h0;
	lo_idx = 4'h0;
	for (int i = 15; i >= 0; i--) begin
		if (hi_w[i])
			hi_idx = 4'(i); // RULE_04
		if (lo_w[i])
			lo_idx = 4'(i);
	end
end
tlvic_cls_t win_cls_w;
tlvic_cls_t cur_cls_w;
logic [3:0] win_idx_w;
logic [15:0] per_vec_w;
logic [15:0] vec_w;
logic req_next;
// debug classes bypass the global enable
assign win_cls_w = (dbg_flag_reg | bkpt_flag_reg) ? CLS_DBG :
	(|hi_w) ? CLS_HIGH : (|lo_w) ? CLS_LOW : CLS_NONE; // RULE_11
assign win_idx_w = (|hi_w) ? hi_idx : lo_idx; // RULE_04
assign per_vec_w = `TLVIC_VEC_BASE + {9'h000, win_idx_w, 3'b000}; // RULE_05
assign vec_w = dbg_flag_reg ? {`TLVIC_RELOC_NIBBLE, `TLVIC_DBG_VEC_LOW} :
	bkpt_flag_reg ? {`TLVIC_RELOC_NIBBLE, `TLVIC_BKPT_VEC_LOW} : // RULE_09
	reloc_reg ? {`TLVIC_RELOC_NIBBLE, per_vec_w[11:0]} : per_vec_w; // RULE_06
assign cur_cls_w = dbg_is_reg ? CLS_DBG : high_svc_reg ? CLS_HIGH :
	low_svc_reg ? CLS_LOW : CLS_NONE;
// request only above the level in service; drop for one cycle after ack
assign req_next = (win_cls_w > cur_cls_w) && !irq_ack_i; // RULE_26
always_ff @(posedge clk_i) begin
	if (rst_i) begin
		req_reg <= 1'b0;
		vec_reg <= 16'h0000;
		cls_reg <= CLS_NONE;
		idx_reg <= 4'h0;
	end else begin
		req_reg <= req_next; // RULE_03
		if (!irq_ack_i) begin
			vec_reg <= vec_w;
			cls_reg <= win_cls_w;
			idx_reg <= win_idx_w;
		end
	end
end
////////////////////////////////////////////////////////////////////////////////
// service tracking and hardware flag clear
logic take_w;
logic per_take_w;
assign take_w = irq_ack_i & req_reg;
assign per_take_w = take_w && (cls_reg == CLS_HIGH || cls_reg == CLS_LOW);
always_ff @(posedge clk_i) begin
	if (rst_i) begin
		high_svc_reg <= 1'b0;
		low_svc_reg <= 1'b0;
		dbg_is_reg <= 1'b0;
		t0_clr_reg <= 1'b0;
		t1_clr_reg <= 1'b0;
	end else begin
		t0_clr_reg <= per_take_w && idx_reg == `TLVIC_SRC_TIMER0; // RULE_07
		t1_clr_reg <= per_take_w && idx_reg == `TLVIC_SRC_TIMER1;
		if (take_w) begin
			case (cls_reg)
				CLS_DBG: dbg_is_reg <= 1'b1;
				CLS_HIGH: high_svc_reg <= 1'b1; // RULE_23
				CLS_LOW: low_svc_reg <= 1'b1;
				default: low_svc_reg <= low_svc_reg;
			endcase
		end else if (irq_return_i) begin
			// the innermost routine is the one that returns
			if (dbg_is_reg)
				dbg_is_reg <= 1'b0;
			else if (high_svc_reg)
				high_svc_reg <= 1'b0;
			else
				low_svc_reg <= 1'b0;
		end
	end
end
////////////////////////////////////////////////////////////////////////////////
// wake: edges only, no enable involved; stop-mode clocking is outside
logic [15:0] src_rise_w;
logic [7:0] wake_src_w;
assign src_rise_w = src_reg & ~src_prev_reg;
assign wake_src_w = {src_rise_w[14], src_rise_w[13], src_rise_w[12], src_rise_w[10],
	src_rise_w[9], src_rise_w[8], grp_evt_w}; // RULE_18
always_ff @(posedge clk_i) begin
	if (rst_i) begin
		wake_reg <= 1'b0;
		restart_reg <= 1'b0;
	end else begin
		wake_reg <= |(wake_src_w & wake_mask_reg); // RULE_19
		restart_reg <= (|(wake_src_w & wake_mask_reg)) & osc_running_i; // RULE_20
	end
end
////////////////////////////////////////////////////////////////////////////////
// read mux; unmapped indices answer with zero
logic [7:0] ext_flags_w;
logic [7:0] status_w;
logic [7:0] rd_w;
assign ext_flags_w = {src_reg[14:12], 1'b0, src_reg[10:8], i2c_mst_flag_reg}; // RULE_15
assign status_w = {high_svc_reg, low_svc_reg, dbg_is_reg, 3'b000, dbg_flag_reg, bkpt_flag_reg};
assign rd_w = (idx_w == `TLVIC_IDX_EXT_FLAGS) ? ext_flags_w :
	(idx_w == `TLVIC_IDX_RELOC) ? {2'b00, reloc_reg, 5'h00} :
	(idx_w == `TLVIC_IDX_WAKE_MASK) ? wake_mask_reg :
	(idx_w == `TLVIC_IDX_PIN_RISE) ? pin_rise_reg :
	(idx_w == `TLVIC_IDX_PIN_FALL) ? pin_fall_reg :
	(idx_w == `TLVIC_IDX_PIN_FLAGS) ? {6'h00, pin_flag_reg} :
	(idx_w == `TLVIC_IDX_BASIC_EN) ? basic_en_reg :
	(idx_w == `TLVIC_IDX_BASIC_PRIO) ? {1'b0, basic_prio_reg} :
	(idx_w == `TLVIC_IDX_STATUS) ? status_w : // RULE_23
	(idx_w == `TLVIC_IDX_UNLOCK) ? {7'h00, unlocked_w} :
	(idx_w == `TLVIC_IDX_EXT_EN) ? ext_en_reg :
	(idx_w == `TLVIC_IDX_EXT_PRIO) ? ext_prio_reg : 8'h00;
always_ff @(posedge clk_i) begin
	if (rst_i) begin
		ack_reg <= 1'b0;
		dat_reg <= 32'h00000000;
	end else begin
		ack_reg <= bus_req_w & ~ack_reg;
		if (bus_req_w & ~ack_reg)
			dat_reg <= {24'h000000, rd_w};
	end
end
assign ack_o = ack_reg;
assign dat_o = dat_reg;
assign irq_req_o = req_reg;
assign irq_vector_o = vec_reg;
assign timer0_flag_clear_o = t0_clr_reg;
assign timer1_flag_clear_o = t1_clr_reg;
assign wake_o = wake_reg;
assign clk_restart_o = restart_reg;
////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);
property p_gie_off;
	!basic_en_reg[`TLVIC_GIE_BIT] && !dbg_flag_reg && !bkpt_flag_reg |=> !irq_req_o;
endproperty
a_gie_off: assert property (p_gie_off) else $error("request with global enable off"); // RULE_12
property p_dbg_vec;
	dbg_flag_reg && !dbg_is_reg && !irq_ack_i |=>
		irq_req_o && irq_vector_o == {`TLVIC_RELOC_NIBBLE, `TLVIC_DBG_VEC_LOW};
endproperty
a_dbg_vec: assert property (p_dbg_vec) else $error("debug vector not presented"); // RULE_09
property p_ack_drop;
	irq_ack_i |=> !irq_req_o;
endproperty
a_ack_drop: assert property (p_ack_drop) else $error("request held after ack"); // RULE_03
property p_t0_clear;
	per_take_w && idx_reg == `TLVIC_SRC_TIMER0 |=> timer0_flag_clear_o ##1 !timer0_flag_clear_o;
endproperty
a_t0_clear: assert property (p_t0_clear) else $error("timer0 flag clear missing"); // RULE_07
property p_no_set;
	!i2c_mst_flag_reg && !i2c_mst_in_reg && wr_ext_flags_w |=> !i2c_mst_flag_reg;
endproperty
a_no_set: assert property (p_no_set) else $error("software set a flag"); // RULE_08
property p_wake_lock;
	!unlocked_w && wr_w && idx_w == `TLVIC_IDX_WAKE_MASK |=> $stable(wake_mask_reg);
endproperty
a_wake_lock: assert property (p_wake_lock) else $error("locked mask written"); // RULE_22
property p_unlock_end;
	unlk_cnt_reg == 9'd1 && !wr_unlock_w |=> !unlocked_w;
endproperty
a_unlock_end: assert property (p_unlock_end) else $error("window outlived count"); // RULE_24
property p_high_block;
	high_svc_reg && !dbg_flag_reg && !bkpt_flag_reg |=> !irq_req_o;
endproperty
a_high_block: assert property (p_high_block) else $error("high service preempted"); // RULE_26
property p_restart;
	clk_restart_o |-> wake_o && $past(osc_running_i);
endproperty
a_restart: assert property (p_restart) else $error("restart without oscillator"); // RULE_20
c_dbg_taken: cover property (take_w && cls_reg == CLS_DBG);
c_preempt: cover property (low_svc_reg && take_w && cls_reg == CLS_HIGH);
c_wake: cover property (wake_o && !irq_req_o);
c_unlock: cover property ($rose(unlocked_w));
endmodule // tlvic_top

// *** verification/tlvic_core_model.sv ***
`timescale 1ns/100ps
// core side: takes one vector at a time, runs a fixed-length service, then returns
module tlvic_core_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic irq_req_i,
	input wire logic [15:0] irq_vector_i,
	input wire logic slow_i,
	output logic irq_ack_o,
	output logic irq_return_o,
	output logic [15:0] taken_vec_o,
	output int taken_cnt_o
);
	int wait_cnt;
	int svc_cnt;
	// no nesting here: the bench never asks for a preempting request
	always @(posedge clk_i) begin
		irq_ack_o <= 1'b0;
		irq_return_o <= 1'b0;
		if (rst_i) begin
			wait_cnt <= 0;
			svc_cnt <= 0;
			taken_cnt_o <= 0;
			taken_vec_o <= 16'h0000;
		end else if (svc_cnt > 0) begin
			svc_cnt <= svc_cnt - 1;
			if (svc_cnt == 1) begin
				irq_return_o <= 1'b1;
			end
		end else if (irq_req_i === 1'b1) begin
			wait_cnt <= wait_cnt + 1;
			if (wait_cnt >= (slow_i ? 3 : 0)) begin
				irq_ack_o <= 1'b1;
				taken_vec_o <= irq_vector_i;
				taken_cnt_o <= taken_cnt_o + 1;
				svc_cnt <= 30;
				wait_cnt <= 0;
			end
		end
	end
endmodule // tlvic_core_model

// *** verification/testbench.sv ***
`timescale 1ns/100ps
module testbench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] dat_o;
	logic ack_o;
	logic [12:0] src = 13'h0000;
	logic [7:0] pin0 = 8'h00, pin1 = 8'h00, did = 8'h00, dcfg = 8'h5a;
	logic dmode = 1'b0, dreq = 1'b0, bkpt = 1'b0, i2c_mst = 1'b0, osc = 1'b1, slow = 1'b0;
	logic irq_req, clr0, clr1, wake, crst, ack_core, ret_core;
	logic [15:0] vec, tvec;
	int tcnt;
	int miscompares = 0, checks_done = 0, nclr0 = 0, nclr1 = 0, nwake = 0, nrst = 0;
	logic [7:0] basic_en = 8'h00, basic_pri = 8'h00, ext_en = 8'h00, ext_pri = 8'h00;
	logic reloc = 1'b0;
	int pos_t[14] = '{1, 3, 5, 4, 6, 8, 9, 10, 11, 12, 13, 14, 15, 0};
	int en_t[14] = '{1, 3, 5, 4, 6, 9, 10, 11, 12, 13, 14, 15, -1, 0};
	logic [7:0] ridx[7] = '{8'h91, 8'h9f, 8'ha8, 8'hb8, 8'he8, 8'hf8, 8'h10};
	logic [7:0] rexp[7] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] q;
	int c, w0, r0, ev, pr;

	tlvic_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
		.timer0_overflow_flag_i(src[0]), .timer1_overflow_flag_i(src[1]),
		.timer2_flag_i(src[2]), .uart0_txrx_flags_i(src[3]), .uart2_txrx_flags_i(src[4]),
		.i2c_master_irq_i(i2c_mst), .low_voltage_irq_i(src[5]), .touch_key_irq_i(src[6]),
		.reserved_irq_i(src[7]), .watchdog_irq_flag_i(src[8]),
		.pwm_capture_quad_irq_i(src[9]), .spi_i2cslave_irq_i(src[10]),
		.timers_buzzer_irq_i(src[11]), .mem_error_irq_i(src[12]),
		.pin_group0_pins_i(pin0), .pin_group1_pins_i(pin1), .dbg_port_mode_i(dmode),
		.dbg_host_req_i(dreq), .dbg_host_id_i(did), .dbg_id_cfg_i(dcfg),
		.breakpoint_match_i(bkpt), .irq_ack_i(ack_core), .irq_return_i(ret_core),
		.osc_running_i(osc), .irq_req_o(irq_req), .irq_vector_o(vec),
		.timer0_flag_clear_o(clr0), .timer1_flag_clear_o(clr1), .wake_o(wake),
		.clk_restart_o(crst));
	tlvic_core_model core_u (.clk_i(clk_i), .rst_i(rst_i), .irq_req_i(irq_req),
		.irq_vector_i(vec), .slow_i(slow), .irq_ack_o(ack_core), .irq_return_o(ret_core),
		.taken_vec_o(tvec), .taken_cnt_o(tcnt));

	initial begin
		forever #25 clk_i = ~clk_i;
	end
	// pulses are counted rather than caught, so their exact cycle never matters
	always @(posedge clk_i) begin
		if (clr0 === 1'b1) nclr0++;
		if (clr1 === 1'b1) nclr1++;
		if (wake === 1'b1) nwake++;
		if (crst === 1'b1) nrst++;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
		output logic [7:0] r);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		chk("bus ack", 16'h0001, {15'h0000, ack_o});
		r = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] r;
		bus(1'b1, idx, d, r);
		case (idx)
			8'ha8: basic_en = d;
			8'hb8: basic_pri = d;
			8'he8: ext_en = d;
			8'hf8: ext_pri = d;
			8'h9d: reloc = d[5];
			default: ;
		endcase
	endtask
	task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] e);
		logic [7:0] r;
		bus(1'b0, idx, 8'h00, r);
		chk(nm, {8'h00, e}, {8'h00, r});
	endtask
	// reference arbitration: high level first, then lowest natural position
	function automatic int pick(input logic [13:0] m);
		int best;
		int bh;
		int h;
		logic [15:0] enr;
		logic [15:0] prr;
		best = 99;
		bh = 0;
		enr = {ext_en, basic_en};
		prr = {ext_pri, basic_pri};
		for (int i = 0; i < 14; i++) begin
			h = (en_t[i] < 0) ? 0 : int'(prr[en_t[i]]);
			if (m[i] && basic_en[7] && (en_t[i] < 0 || enr[en_t[i]]) &&
				(h > bh || (h == bh && pos_t[i] < best))) begin
				best = pos_t[i];
				bh = h;
			end
		end
		return (reloc ? 32'h7000 : 0) + 3 + 8 * best + bh * 65536;
	endfunction
	task automatic wtake(input int k);
		int n;
		n = 0;
		while (tcnt == k && n < 200) begin
			@(posedge clk_i);
			n++;
		end
		chk("take wait", 16'h0000, {15'h0000, n >= 200});
	endtask
	task automatic wret();
		int n;
		n = 0;
		while (ret_core !== 1'b1 && n < 200) begin
			@(posedge clk_i);
			n++;
		end
		chk("return wait", 16'h0000, {15'h0000, n >= 200});
		@(posedge clk_i);
	endtask
	task automatic run(input logic [12:0] m, input logic [7:0] p);
		int k;
		int e;
		logic [7:0] r;
		k = tcnt;
		e = pick({p[0], m});
		src <= m;
		pin0 <= p;
		wtake(k);
		chk("vector", e[15:0], tvec);
		bus(1'b0, 8'hc5, 8'h00, r);
		chk("service level", e[16] ? 16'h0080 : 16'h0040, {8'h00, r & 8'hc0});
		src <= 13'h0000;
		wr(8'ha4, 8'h00);
		wret();
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (30000) @(posedge clk_i);
		miscompares++;
		final_report();
	end
	initial begin
		void'($urandom(32'h0d398090));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 7; i++) rdc("reset value", ridx[i], rexp[i]);
		@(posedge clk_i);
		i2c_mst <= 1'b1;
		@(posedge clk_i);
		i2c_mst <= 1'b0;
		rdc("i2c flag set", 8'h91, 8'h01);
		wr(8'h91, 8'hff);
		rdc("i2c flag kept", 8'h91, 8'h01);
		wr(8'h91, 8'hfe);
		rdc("i2c flag cleared", 8'h91, 8'h00);
		wr(8'h91, 8'h01);
		rdc("i2c flag not set", 8'h91, 8'h00);
		for (int k = 0; k < 4; k++) begin
			ev = $urandom;
			src[11:5] <= ev[6:0];
			repeat (3) @(posedge clk_i);
			rdc("ext flags", 8'h91, {ev[6:4], 1'b0, ev[2:0], 1'b0});
		end
		src <= 13'h0000;
		wr(8'ha8, 8'h02);
		src <= 13'h0001;
		repeat (6) @(posedge clk_i);
		chk("gated request", 16'h0000, {15'h0000, irq_req});
		src <= 13'h0000;
		for (int i = 0; i < 13; i++) begin
			ev = (en_t[i] < 0) ? 0 : (1 << en_t[i]);
			pr = $urandom % 2;
			wr(8'ha8, 8'h80 | ev[7:0]);
			wr(8'he8, ev[15:8]);
			wr(8'hb8, pr ? ev[7:0] : 8'h00);
			wr(8'hf8, pr ? ev[15:8] : 8'h00);
			slow <= $urandom % 2;
			run(13'(1 << i), 8'h00);
		end
		chk("timer0 clears", 16'h0001, 16'(nclr0));
		chk("timer1 clears", 16'h0001, 16'(nclr1));
		wr(8'hb8, 8'h00);
		wr(8'hf8, 8'h00);
		wr(8'he8, 8'h00);
		wr(8'ha8, 8'hb0);
		run(13'h000c, 8'h00);
		wr(8'hb8, 8'h20);
		run(13'h000c, 8'h00);
		wr(8'ha2, 8'h01);
		wr(8'ha8, 8'h81);
		run(13'h0000, 8'h01);
		pin0 <= 8'h00;
		// group 1 pin 1 on falling edge only; its enable stays off, so only the flag shows
		wr(8'ha3, 8'h02);
		pin1 <= 8'h02;
		repeat (3) @(posedge clk_i);
		pin1 <= 8'h00;
		repeat (3) @(posedge clk_i);
		rdc("group1 fall flag", 8'ha4, 8'h02);
		wr(8'ha4, 8'h00);
		wr(8'h9f, 8'h00);
		rdc("locked wake mask", 8'h9f, 8'hff);
		wr(8'hc9, 8'haa);
		wr(8'hc9, 8'h55);
		wr(8'h9d, 8'h20);
		wr(8'ha8, 8'h82);
		run(13'h0001, 8'h00);
		wr(8'h9d, 8'h00);
		wr(8'ha8, 8'h00);
		w0 = nwake;
		r0 = nrst;
		src <= 13'h0020;
		repeat (12) @(posedge clk_i);
		chk("wake once", 16'(w0 + 1), 16'(nwake));
		chk("clock restart", 16'(r0 + 1), 16'(nrst));
		src <= 13'h0000;
		wr(8'h9f, 8'hfb);
		rdc("open wake mask", 8'h9f, 8'hfb);
		wr(8'hc9, 8'h00);
		src <= 13'h0020;
		repeat (6) @(posedge clk_i);
		chk("masked wake", 16'(w0 + 1), 16'(nwake));
		osc <= 1'b0;
		src <= 13'h0040;
		repeat (6) @(posedge clk_i);
		chk("wake no osc", 16'(w0 + 2), 16'(nwake));
		chk("no restart", 16'(r0 + 1), 16'(nrst));
		src <= 13'h0000;
		dmode <= 1'b1;
		did <= 8'h33;
		dreq <= 1'b1;
		@(posedge clk_i);
		dreq <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk("wrong debug id", 16'h0000, {15'h0000, irq_req});
		c = tcnt;
		did <= 8'h5a;
		dreq <= 1'b1;
		bkpt <= 1'b1;
		@(posedge clk_i);
		dreq <= 1'b0;
		bkpt <= 1'b0;
		wtake(c);
		chk("debug vector", 16'h70c0, tvec);
		wr(8'hc5, 8'hfd);
		wret();
		wtake(c + 1);
		chk("breakpoint vector", 16'h7080, tvec);
		wr(8'hc5, 8'h00);
		wret();
		final_report();
	end
endmodule // testbench
